//--- hw/panel_timing_pkg.sv
package panel_timing_pkg;
	// Frame geometry in lines
	localparam int unsigned V_ACTIVE = 1080;
	localparam int unsigned V_BLANK_MIN = 35;
	localparam int unsigned V_BLANK_TYP = 45;
	localparam int unsigned V_BLANK_MAX = 55;
	localparam int unsigned V_TOTAL_MIN = 1115;
	localparam int unsigned V_TOTAL_MAX = 1135;
	// Line geometry in pixel-clock cycles
	localparam int unsigned H_ACTIVE = 960;
	localparam int unsigned H_BLANK_MIN = 90;
	localparam int unsigned H_BLANK_TYP = 140;
	localparam int unsigned H_BLANK_MAX = 190;
	localparam int unsigned H_TOTAL_MIN = 1050;
	localparam int unsigned H_TOTAL_MAX = 1150;
	// Clock and rates
	localparam int unsigned SYS_CLK_KHZ = 125000;
	localparam int unsigned PIX_CLK_MIN_KHZ = 60000;
	localparam int unsigned PIX_CLK_MAX_KHZ = 80000;
	localparam int unsigned RATE_SIXTY_HZ = 60;
	localparam int unsigned RATE_FIFTY_HZ = 50;
	localparam int unsigned RATE_FIFTY_MIN_HZ = 47;
	localparam int unsigned RATE_FIFTY_MAX_HZ = 53;
	// Half period of the generated link clock in system cycles
	localparam int unsigned LINK_DIV_HALF = 1;
	// Pixel pair width: two 24-bit pixels
	localparam int unsigned PIXEL_BITS = 24;
	localparam int unsigned PAIR_BITS = 2 * PIXEL_BITS;
	// Power sequencing delays: settle in system cycles, backlight guard in frames
	localparam int unsigned POWER_SETTLE_CYCLES = 16;
	localparam int unsigned BACKLIGHT_GUARD_FRAMES = 2;
	// Sequencer states, Gray along the power path except DRAIN back to OFF
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_POWER = 3'b001,
		ST_VIDEO = 3'b011,
		ST_LIGHT = 3'b010,
		ST_DARK = 3'b110,
		ST_DRAIN = 3'b111
	} seq_state_t;
endpackage

//--- hw/pair_fifo_if.sv
`timescale 1ns/1ps
interface pair_fifo_if #(parameter int unsigned WIDTH = 48);
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;
	modport fifo (input in_valid, input in_data, output in_ready, output out_valid, output out_data, input out_ready);
	modport user (output in_valid, output in_data, input in_ready, input out_valid, input out_data, output out_ready);
endinterface

//--- hw/pair_fifo.sv
`timescale 1ns/1ps
module pair_fifo #(
	parameter int unsigned WIDTH = 48,
	parameter int unsigned DEPTH = 4
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Stream ports
	pair_fifo_if.fifo port
);
	localparam int unsigned AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("pair_fifo depth must be a power of two of at least 2");
		end
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic do_wr;
	logic do_rd;

	// Full when pointers differ only in the wrap bit
	assign port.in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign port.out_valid = wr_ptr != rd_ptr;
	assign port.out_data = mem[rd_ptr[AW-1:0]];
	assign do_wr = port.in_valid && port.in_ready;
	assign do_rd = port.out_valid && port.out_ready;

	// Storage
	always_ff @(posedge sys_clk_i) begin
		if (do_wr) begin
			mem[wr_ptr[AW-1:0]] <= port.in_data;
		end
	end

	// Pointers
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

//--- hw/panel_timing_host.sv
`timescale 1ns/1ps
module panel_timing_host #(
	parameter int unsigned H_BLANK = panel_timing_pkg::H_BLANK_TYP,
	parameter int unsigned V_BLANK_60 = panel_timing_pkg::V_BLANK_TYP,
	parameter int unsigned V_BLANK_50 = panel_timing_pkg::V_BLANK_TYP,
	parameter int unsigned FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// User control
	input wire logic enable_i,
	input wire logic rate_fifty_mode_i,
	// Pixel pair stream, odd pixel in the low half
	input wire logic pair_valid_i,
	input wire logic [panel_timing_pkg::PAIR_BITS-1:0] pair_data_i,
	output logic pair_ready_o,
	// Status
	output logic frame_start_o,
	output logic underrun_o,
	output logic [2:0] state_o,
	// Panel link
	output logic panel_power_o,
	output logic backlight_on_o,
	output logic frame_rate_select_o,
	output logic link_clk_o,
	output logic data_enable_o,
	output logic [panel_timing_pkg::PAIR_BITS-1:0] pixel_pair_o
);
	localparam int unsigned H_TOTAL = panel_timing_pkg::H_ACTIVE + H_BLANK;
	localparam int unsigned V_TOTAL_60 = panel_timing_pkg::V_ACTIVE + V_BLANK_60;
	localparam int unsigned V_TOTAL_50 = panel_timing_pkg::V_ACTIVE + V_BLANK_50;
	localparam int unsigned LINK_KHZ = panel_timing_pkg::SYS_CLK_KHZ / (2 * panel_timing_pkg::LINK_DIV_HALF);
	localparam int unsigned HW = 11;

	// Refuse geometry the panel cannot accept
	initial begin
		if (H_BLANK < panel_timing_pkg::H_BLANK_MIN || H_BLANK > panel_timing_pkg::H_BLANK_MAX) begin
			$error("horizontal blanking out of range");
		end
		if (H_TOTAL < panel_timing_pkg::H_TOTAL_MIN || H_TOTAL > panel_timing_pkg::H_TOTAL_MAX) begin
			$error("line total out of range");
		end
		if (V_BLANK_60 < panel_timing_pkg::V_BLANK_MIN || V_BLANK_60 > panel_timing_pkg::V_BLANK_MAX
			|| V_BLANK_50 < panel_timing_pkg::V_BLANK_MIN || V_BLANK_50 > panel_timing_pkg::V_BLANK_MAX) begin
			$error("vertical blanking out of range");
		end
		if (V_TOTAL_60 < panel_timing_pkg::V_TOTAL_MIN || V_TOTAL_60 > panel_timing_pkg::V_TOTAL_MAX
			|| V_TOTAL_50 < panel_timing_pkg::V_TOTAL_MIN || V_TOTAL_50 > panel_timing_pkg::V_TOTAL_MAX) begin
			$error("frame total out of range");
		end
		if (LINK_KHZ < panel_timing_pkg::PIX_CLK_MIN_KHZ || LINK_KHZ > panel_timing_pkg::PIX_CLK_MAX_KHZ) begin
			$error("link clock out of range");
		end
		if (FIFO_DEPTH < 2) begin
			$error("fifo depth too small");
		end
	end

	// Totals must fit the clock window at both nominal rates
	initial begin
		if (longint'(panel_timing_pkg::RATE_SIXTY_HZ) * V_TOTAL_60 * H_TOTAL
			> longint'(panel_timing_pkg::PIX_CLK_MAX_KHZ) * 1000) begin
			$error("sixty-hertz totals exceed the fastest clock");
		end
		if (longint'(panel_timing_pkg::RATE_FIFTY_HZ) * V_TOTAL_50 * H_TOTAL
			< longint'(panel_timing_pkg::PIX_CLK_MIN_KHZ) * 1000) begin
			$error("fifty-hertz totals fall short of the slowest clock");
		end
	end

	// Fifty-hertz rate follows from our fixed link clock and the totals
	// Limitation: sixty hertz needs a link clock above 70 MHz, beyond this divider
	initial begin
		if (longint'(LINK_KHZ) * 1000 < longint'(panel_timing_pkg::RATE_FIFTY_MIN_HZ) * V_TOTAL_50 * H_TOTAL
			|| longint'(LINK_KHZ) * 1000 > longint'(panel_timing_pkg::RATE_FIFTY_MAX_HZ) * V_TOTAL_50 * H_TOTAL) begin
			$error("fifty-hertz frame rate out of range");
		end
	end

	pair_fifo_if #(.WIDTH(panel_timing_pkg::PAIR_BITS)) fifo_bus ();

	pair_fifo #(
		.WIDTH(panel_timing_pkg::PAIR_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.port(fifo_bus.fifo)
	);

	panel_timing_pkg::seq_state_t state;
	panel_timing_pkg::seq_state_t next_state;
	logic [7:0] wait_cnt;
	logic [1:0] frame_cnt;
	logic div_cnt;
	logic link_rise;
	logic [HW-1:0] h_cnt;
	logic [HW-1:0] v_cnt;
	logic [HW-1:0] v_total;
	logic rate_fifty;
	logic line_end;
	logic frame_end;
	logic active;
	logic run_video;
	logic [1:0] enable_sync;
	logic [1:0] rate_sync;
	logic enable_req;
	logic rate_fifty_req;

	// Two-flop capture; controls may come from a strap or another clock
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			enable_sync <= 2'b00;
			rate_sync <= 2'b00;
		end else begin
			enable_sync <= {enable_sync[0], enable_i};
			rate_sync <= {rate_sync[0], rate_fifty_mode_i};
		end
	end
	assign enable_req = enable_sync[1];
	assign rate_fifty_req = rate_sync[1];

	assign run_video = state == panel_timing_pkg::ST_VIDEO || state == panel_timing_pkg::ST_LIGHT
		|| state == panel_timing_pkg::ST_DARK;
	assign line_end = h_cnt == HW'(H_TOTAL - 1);
	assign frame_end = line_end && v_cnt == v_total - 1'b1;
	assign active = h_cnt < HW'(panel_timing_pkg::H_ACTIVE) && v_cnt < HW'(panel_timing_pkg::V_ACTIVE);
	assign v_total = rate_fifty ? HW'(V_TOTAL_50) : HW'(V_TOTAL_60);
	// Drain the FIFO only on active link cycles; stall stays honest otherwise
	assign fifo_bus.in_valid = pair_valid_i;
	assign fifo_bus.in_data = pair_data_i;
	assign fifo_bus.out_ready = link_rise && active && run_video;

	// Link clock divider; the panel samples on our rising edge
	// Stops with the power pin, so the clock never runs into an unpowered panel
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			div_cnt <= 1'b0;
			link_clk_o <= 1'b0;
		end else if (next_state == panel_timing_pkg::ST_OFF) begin
			div_cnt <= 1'b0;
			link_clk_o <= 1'b0;
		end else begin
			div_cnt <= ~div_cnt;
			link_clk_o <= ~link_clk_o;
		end
	end

	// Counters advance once per link cycle, on the edge that drops the clock
	assign link_rise = link_clk_o && div_cnt;

	// Horizontal and vertical position, rate latched at frame boundary and while video is stopped
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			h_cnt <= '0;
			v_cnt <= '0;
			rate_fifty <= 1'b0;
		end else if (!run_video) begin
			h_cnt <= '0;
			v_cnt <= '0;
			rate_fifty <= rate_fifty_req;
		end else if (link_rise) begin
			if (line_end) begin
				h_cnt <= '0;
				if (frame_end) begin
					v_cnt <= '0;
					rate_fifty <= rate_fifty_req;
				end else begin
					v_cnt <= v_cnt + 1'b1;
				end
			end else begin
				h_cnt <= h_cnt + 1'b1;
			end
		end
	end

	// Data enable and pixel pair; no sync outputs exist at all
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			data_enable_o <= 1'b0;
			pixel_pair_o <= '0;
			underrun_o <= 1'b0;
		end else if (!run_video) begin
			data_enable_o <= 1'b0;
			pixel_pair_o <= '0;
			underrun_o <= 1'b0;
		end else if (link_rise) begin
			data_enable_o <= active;
			// Starved source sends black so the line count stays exact
			pixel_pair_o <= (active && fifo_bus.out_valid) ? fifo_bus.out_data : '0;
			underrun_o <= active && !fifo_bus.out_valid;
		end
	end

	// Start-of-frame pulse for the source to align its first pair
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			frame_start_o <= 1'b0;
		end else begin
			frame_start_o <= run_video && link_rise && frame_end;
		end
	end

	// Ready is registered and one cycle late; the FIFO has no slack and drops a push made while full
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			pair_ready_o <= 1'b0;
		end else begin
			pair_ready_o <= fifo_bus.in_ready;
		end
	end

	// Power and backlight sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			panel_timing_pkg::ST_OFF: begin
				if (enable_req) begin
					next_state = panel_timing_pkg::ST_POWER;
				end
			end
			panel_timing_pkg::ST_POWER: begin
				if (wait_cnt == 8'(panel_timing_pkg::POWER_SETTLE_CYCLES)) begin
					next_state = panel_timing_pkg::ST_VIDEO;
				end
			end
			panel_timing_pkg::ST_VIDEO: begin
				if (!enable_req) begin
					next_state = panel_timing_pkg::ST_DRAIN;
				end else if (frame_cnt == 2'(panel_timing_pkg::BACKLIGHT_GUARD_FRAMES)) begin
					next_state = panel_timing_pkg::ST_LIGHT;
				end
			end
			panel_timing_pkg::ST_LIGHT: begin
				if (!enable_req) begin
					next_state = panel_timing_pkg::ST_DARK;
				end
			end
			panel_timing_pkg::ST_DARK: begin
				if (frame_cnt == 2'(panel_timing_pkg::BACKLIGHT_GUARD_FRAMES)) begin
					next_state = panel_timing_pkg::ST_DRAIN;
				end
			end
			panel_timing_pkg::ST_DRAIN: begin
				if (wait_cnt == 8'(panel_timing_pkg::POWER_SETTLE_CYCLES)) begin
					next_state = panel_timing_pkg::ST_OFF;
				end
			end
			default: begin
				next_state = panel_timing_pkg::ST_OFF;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			state <= panel_timing_pkg::ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// Settle and frame counters restart on each state change
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			wait_cnt <= '0;
			frame_cnt <= '0;
		end else if (next_state != state) begin
			wait_cnt <= '0;
			frame_cnt <= '0;
		end else begin
			if (wait_cnt != 8'hff) begin
				wait_cnt <= wait_cnt + 1'b1;
			end
			if (link_rise && frame_end && frame_cnt != 2'h3) begin
				frame_cnt <= frame_cnt + 1'b1;
			end
		end
	end

	// Panel pins; select is driven, never floated, while powered
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			panel_power_o <= 1'b0;
			backlight_on_o <= 1'b0;
			frame_rate_select_o <= 1'b0;
			state_o <= 3'h0;
		end else begin
			panel_power_o <= next_state != panel_timing_pkg::ST_OFF;
			backlight_on_o <= next_state == panel_timing_pkg::ST_LIGHT;
			frame_rate_select_o <= (next_state != panel_timing_pkg::ST_OFF) && !rate_fifty;
			state_o <= next_state;
		end
	end
endmodule

//--- dv/panel_timing_host_sva.sv
`timescale 1ns/1ps
module panel_timing_host_sva #(
	parameter int unsigned H_BLANK = 140
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Watched outputs
	input wire logic underrun_o,
	input wire logic panel_power_o,
	input wire logic backlight_on_o,
	input wire logic frame_rate_select_o,
	input wire logic link_clk_o,
	input wire logic data_enable_o,
	input wire logic [panel_timing_pkg::PAIR_BITS-1:0] pixel_pair_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	logic [15:0] hi_cnt;
	logic [15:0] lo_cnt;
	// High run of data enable in system cycles
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i || !data_enable_o) hi_cnt <= 16'h0000;
		else hi_cnt <= hi_cnt + 16'h0001;
	end
	// Low run; starts saturated so the gap before video is never judged
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) lo_cnt <= 16'hffff;
		else if (data_enable_o) lo_cnt <= 16'h0000;
		else if (lo_cnt != 16'hffff) lo_cnt <= lo_cnt + 16'h0001;
	end
	property p_off_low;
		!panel_power_o |-> !data_enable_o && !link_clk_o && !frame_rate_select_o && pixel_pair_o == '0;
	endproperty
	a_off_low: assert property (p_off_low) else $error("link active while unpowered");
	property p_blank_zero;
		!data_enable_o |-> pixel_pair_o == '0;
	endproperty
	a_blank_zero: assert property (p_blank_zero) else $error("pair data outside active");
	property p_light;
		backlight_on_o |-> panel_power_o;
	endproperty
	a_light: assert property (p_light) else $error("backlight without panel power");
	property p_act_len;
		$fell(data_enable_o) |-> hi_cnt == 2 * panel_timing_pkg::H_ACTIVE;
	endproperty
	a_act_len: assert property (p_act_len) else $error("active run length wrong");
	property p_blank_len;
		$rose(data_enable_o) && lo_cnt < 2 * (panel_timing_pkg::H_ACTIVE + H_BLANK) |-> lo_cnt == 2 * H_BLANK;
	endproperty
	a_blank_len: assert property (p_blank_len) else $error("line blanking length wrong");
	property p_edge;
		$changed(data_enable_o) || $changed(pixel_pair_o) |-> $fell(link_clk_o);
	endproperty
	a_edge: assert property (p_edge) else $error("link data moved off falling edge");
	property p_div;
		$rose(link_clk_o) |=> $fell(link_clk_o);
	endproperty
	a_div: assert property (p_div) else $error("link clock high too long");
	property p_under;
		underrun_o |-> data_enable_o && pixel_pair_o == '0;
	endproperty
	a_under: assert property (p_under) else $error("underrun slot not zero");
endmodule
bind panel_timing_host panel_timing_host_sva #(.H_BLANK(H_BLANK)) i_panel_timing_host_sva (.sys_clk_i, .rstn_i,
	.underrun_o, .panel_power_o, .backlight_on_o, .frame_rate_select_o, .link_clk_o, .data_enable_o, .pixel_pair_o);

//--- dv/panel_model.sv
`timescale 1ns/1ps
module panel_model (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Panel link
	input wire logic link_clk_i,
	input wire logic data_enable_i,
	input wire logic frame_rate_select_i,
	input wire logic [panel_timing_pkg::PAIR_BITS-1:0] pixel_pair_i,
	// What the panel saw
	output logic pair_seen_o,
	output logic [panel_timing_pkg::PAIR_BITS-1:0] pair_o,
	output logic [15:0] act_len_o,
	output logic [15:0] blank_len_o,
	output logic [15:0] lines_o,
	output logic rate_sixty_o
);
	logic clk_q;
	logic de_q;
	logic rise;
	logic [15:0] run;
	// Link edges found by sampling, so no second domain
	assign rise = link_clk_i && !clk_q;
	assign rate_sixty_o = frame_rate_select_i;
	always_ff @(posedge sys_clk_i) begin
		clk_q <= rstn_i && link_clk_i;
	end
	// Positions come from data enable alone
	always_ff @(posedge sys_clk_i) begin
		pair_seen_o <= rstn_i && rise && data_enable_i;
		if (!rstn_i) begin
			de_q <= 1'b0;
			run <= 16'h0000;
			lines_o <= 16'h0000;
		end else if (rise) begin
			pair_o <= pixel_pair_i;
			de_q <= data_enable_i;
			run <= (data_enable_i != de_q) ? 16'h0001 : run + 16'h0001;
			if (de_q && !data_enable_i) act_len_o <= run;
			if (de_q && !data_enable_i) lines_o <= lines_o + 16'h0001;
			if (!de_q && data_enable_i) blank_len_o <= run;
		end
	end
endmodule

//--- dv/test_panel_timing_host.sv
`timescale 1ns/1ps
module test_panel_timing_host;
	localparam int unsigned HB = 100;
	logic sys_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic enable_i = 1'b0;
	logic rate_fifty_mode_i = 1'b0;
	logic pair_valid_i = 1'b0;
	logic [panel_timing_pkg::PAIR_BITS-1:0] pair_data_i = '0;
	logic pair_ready_o, underrun_o, panel_power_o, backlight_on_o, frame_rate_select_o, link_clk_o, data_enable_o;
	logic [panel_timing_pkg::PAIR_BITS-1:0] pixel_pair_o, seen_pair;
	logic seen;
	logic under_d;
	logic rate_sixty;
	logic [15:0] act_len, blank_len, lines;
	logic [panel_timing_pkg::PAIR_BITS-1:0] q[$];
	logic [31:0] seed = 32'h0000ee8e;
	int n_fail = 0;
	int total_checks = 0;
	panel_timing_host #(.H_BLANK(HB), .V_BLANK_60(35), .V_BLANK_50(55), .FIFO_DEPTH(4)) i_panel_timing_host (
		.sys_clk_i, .rstn_i, .enable_i, .rate_fifty_mode_i, .pair_valid_i, .pair_data_i, .pair_ready_o,
		.frame_start_o(), .underrun_o, .state_o(), .panel_power_o, .backlight_on_o, .frame_rate_select_o,
		.link_clk_o, .data_enable_o, .pixel_pair_o);
	panel_model i_panel_model (.sys_clk_i, .rstn_i, .link_clk_i(link_clk_o), .data_enable_i(data_enable_o),
		.frame_rate_select_i(frame_rate_select_o), .pixel_pair_i(pixel_pair_o), .pair_seen_o(seen),
		.pair_o(seen_pair), .act_len_o(act_len), .blank_len_o(blank_len), .lines_o(lines), .rate_sixty_o(rate_sixty));
	initial begin
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d fails=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Push spaced three cycles apart, since ready lags fullness
	task automatic fill(output int n);
		n = 0;
		repeat (3) @(posedge sys_clk_i);
		while (pair_ready_o === 1'b1 && n < 8) begin
			seed = xs(seed);
			pair_valid_i <= 1'b1;
			pair_data_i <= {seed[15:0], seed};
			@(posedge sys_clk_i);
			q.push_back(pair_data_i);
			pair_valid_i <= 1'b0;
			n++;
			repeat (2) @(posedge sys_clk_i);
		end
	endtask
	// Underrun flag of the slot the panel last took; it moves on with the next slot
	always @(posedge sys_clk_i) begin
		under_d <= underrun_o;
	end
	// Each pair the panel takes is the next queued one, or zero on underrun
	always @(posedge sys_clk_i) begin
		if (seen === 1'b1) begin
			if (q.size() > 0) begin
				check(seen_pair, q.pop_front());
				check(under_d, 1'b0);
			end else begin
				check(seen_pair, 48'h0);
				check(under_d, 1'b1);
			end
		end
	end
	initial begin
		repeat (30000) @(posedge sys_clk_i);
		n_fail++;
		$display("watchdog expired");
		conclude();
	end
	initial begin
		int n;
		repeat (16) @(posedge sys_clk_i);
		check({panel_power_o, link_clk_o, data_enable_o, frame_rate_select_o, pixel_pair_o}, 0);
		rstn_i <= 1'b1;
		fill(n);
		check(n, 4);
		$display("test fill done");
		seed = xs(seed);
		rate_fifty_mode_i <= seed[0];
		enable_i <= 1'b1;
		// Lines start with four pairs then run dry; refill in blanking
		for (int i = 1; i <= 4; i++) begin
			for (int w = 0; w < 3000 && lines != i; w++) @(posedge sys_clk_i);
			check(act_len, panel_timing_pkg::H_ACTIVE);
			if (i > 1) check(blank_len, HB);
			check(rate_sixty, !rate_fifty_mode_i);
			check({panel_power_o, backlight_on_o}, 2'b10);
			check($isunknown({panel_power_o, link_clk_o, data_enable_o, frame_rate_select_o, pixel_pair_o}), 0);
			fill(n);
			check(n, 4);
			$display("test line %0d done", i);
		end
		// Reset in line blanking drops the whole link
		rstn_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		check({panel_power_o, link_clk_o, data_enable_o, frame_rate_select_o, pixel_pair_o}, 0);
		$display("test reset done");
		conclude();
	end
endmodule
